//--- bst_pkg.sv
// Shared constants, state enumeration and carrier types of the boundary-scan test port.
`default_nettype none
package bst_pkg;

   // Width of the instruction register and of the pattern it captures.
   localparam int IR_WIDTH = 4;

   // Fixed pattern loaded into the instruction shift stages in Capture-IR.
   localparam logic [IR_WIDTH-1:0] IR_CAPTURE_PATTERN = 4'h9;

   // Instruction codes; any code not listed here selects the single-stage pass register.
   localparam logic [IR_WIDTH-1:0] INSTR_EXTEST = 4'h0;
   localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE = 4'h1;
   localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 4'hf;

   // Number of cells in the pin cell chain register.
   localparam int CELL_COUNT = 16;

   // Rising test clock edges with mode select high that always reach Test-Logic-Reset.
   localparam int TMS_RESET_EDGES = 5;

   // Test-access-port controller states.
   typedef enum logic [3:0] {
      ST_RESET,
      ST_IDLE,
      ST_SEL_DR,
      ST_CAPTURE_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPDATE_DR,
      ST_SEL_IR,
      ST_CAPTURE_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPDATE_IR
   } bst_state_t;

   // Data register actions decoded from the controller state.
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
   } bst_dr_ctl_t;

   // Serial output pin: value and output enable.
   typedef struct packed {
      logic drive;
      logic enable;
   } bst_tdo_t;

endpackage
`default_nettype wire

//--- bst_scan_host.sv
// Scan controller model that drives the four tester pins of the test port and samples TDO.
`timescale 1ns/1ps
`default_nettype none
module bst_scan_host (
   output logic TCK,
   output logic TMS,
   output logic TDI,
   output logic TRST_N,
   input wire logic TDO,
   input wire logic TDO_OE
);
   logic junk;
   logic last_tdo;
   logic quiet;

   // Pins start with test reset low and the test clock standing still.
   initial
   begin
      TCK = 1'b0;
      TMS = 1'b1;
      TDI = 1'b0;
      TRST_N = 1'b0;
      junk = 1'b0;
      last_tdo = 1'b0;
      quiet = 1'b1;
   end

   // One test clock period; a released TDO line is seen as the inverse of its last level.
   task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
      TMS <= tms;
      TDI <= tdi;
      #7.5;
      TCK <= 1'b1;
      tdo = TDO_OE ? TDO : ~last_tdo;
      last_tdo = tdo;
      oe = TDO_OE;
      #7.5;
      TCK <= 1'b0;
   endtask

   // A period outside shifting; TDI toggles so that the device cannot rely on it.
   task automatic q(input logic tms);
      logic b;
      logic oe;
      tick(tms, junk, b, oe);
      junk = ~junk;
      if (oe)
         quiet = 1'b0;
   endtask

   // Several periods at one mode select level; five high ones reach Test-Logic-Reset.
   task automatic run(input logic tms, input int n);
      repeat (n) q(tms);
   endtask

   // Pulses test reset low for 20 ns.
   task automatic trst_pulse;
      TRST_N <= 1'b0;
      #20;
      TRST_N <= 1'b1;
   endtask

   // Walks Idle through one IR or DR scan back to Idle, with one optional pause.
   task automatic scan(input logic ir, input int n, input logic [15:0] din, input int pause_at,
      output logic [15:0] dout, output logic oe_ok);
      logic b;
      logic oe;
      dout = 16'h0000;
      quiet = 1'b1;
      q(1'b1);
      if (ir)
         q(1'b1);
      q(1'b0);
      q(1'b0);
      for (int i = 0; i < n; i++)
      begin
         tick((i == n - 1) || (i == pause_at - 1), din[i], b, oe);
         dout[i] = b;
         if (!oe)
            quiet = 1'b0;
         if (i == pause_at - 1 && i != n - 1)
         begin
            q(1'b0);
            q(1'b0);
            q(1'b1);
            q(1'b0);
         end
      end
      q(1'b1);
      q(1'b0);
      oe_ok = quiet;
   endtask
endmodule
`default_nettype wire

//--- bst_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // The first stage feeds only the second stage.
   always_comb
   begin
      next_meta = d;
      next_q = meta;
   end

   // Data stages need no reset; they settle within two edges.
   always_ff @(posedge clk)
   begin
      meta <= next_meta;
      q <= next_q;
   end

endmodule
`default_nettype wire

//--- bst_tap.sv
// Boundary-scan test access port: controller, instruction, pass and pin cell chain registers.
`timescale 1ns/1ps
`default_nettype none
module bst_tap (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   input wire logic TRST_N,
   output logic TDO,
   output logic TDO_OE,
   input wire logic [bst_pkg::CELL_COUNT-1:0] PIN_SENSE,
   output logic [bst_pkg::CELL_COUNT-1:0] PIN_DRIVE,
   output logic PIN_TEST_MODE
);

   // Test clock domain state.
   bst_pkg::bst_state_t state;
   bst_pkg::bst_state_t next_state;
   logic [bst_pkg::IR_WIDTH-1:0] ir_shift;
   logic [bst_pkg::IR_WIDTH-1:0] next_ir_shift;
   logic [bst_pkg::IR_WIDTH-1:0] ir_cur;
   logic [bst_pkg::IR_WIDTH-1:0] next_ir_cur;
   logic pass_stage;
   logic next_pass_stage;
   logic [bst_pkg::CELL_COUNT-1:0] chain;
   logic [bst_pkg::CELL_COUNT-1:0] next_chain;
   logic [bst_pkg::CELL_COUNT-1:0] cell_latch;
   logic [bst_pkg::CELL_COUNT-1:0] next_cell_latch;
   logic upd_toggle;
   logic next_upd_toggle;
   bst_pkg::bst_tdo_t tdo_q;
   bst_pkg::bst_tdo_t next_tdo_q;
   bst_pkg::bst_dr_ctl_t dr_ctl;
   logic sel_chain;
   logic rst_tck;
   logic tck_rst;
   logic [bst_pkg::CELL_COUNT-1:0] sense_tck;

   // System clock domain state.
   logic upd_toggle_clk;
   logic upd_seen;
   logic next_upd_seen;
   logic extest_clk;
   logic [bst_pkg::CELL_COUNT-1:0] pin_drive;
   logic [bst_pkg::CELL_COUNT-1:0] next_pin_drive;
   logic test_mode;
   logic next_test_mode;

   // Power-up reset is carried into the test clock domain as a level.
   bst_sync #(.WIDTH(1)) u_rst_sync (
      .clk(TCK),
      .d(RST),
      .q(rst_tck)
   );

   // Pin levels are brought into the test clock domain before capture.
   bst_sync #(.WIDTH(bst_pkg::CELL_COUNT)) u_sense_sync (
      .clk(TCK),
      .d(PIN_SENSE),
      .q(sense_tck)
   );

   // Update events and the test mode level cross back to the system clock.
   bst_sync #(.WIDTH(2)) u_back_sync (
      .clk(CLOCK),
      .d({upd_toggle, (ir_cur == bst_pkg::INSTR_EXTEST)}),
      .q({upd_toggle_clk, extest_clk})
   );

   // Either reset source, used to silence checks.
   assign tck_rst = !TRST_N || rst_tck;

   // Unknown instructions fall back to the single-stage pass register.
   assign sel_chain = (ir_cur == bst_pkg::INSTR_EXTEST) ||
                      (ir_cur == bst_pkg::INSTR_SAMPLE);

   // Data register actions decoded from the controller state.
   always_comb
   begin
      dr_ctl.capture = (state == bst_pkg::ST_CAPTURE_DR);
      dr_ctl.shift = (state == bst_pkg::ST_SHIFT_DR);
      dr_ctl.update = (state == bst_pkg::ST_UPDATE_DR);
   end

   // Controller transition graph; each successor depends on mode select.
   always_comb
   begin
      next_state = state;
      case (state)
         bst_pkg::ST_RESET:
            next_state = TMS ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE:
            next_state = TMS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR:
            next_state = TMS ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAPTURE_DR;
         bst_pkg::ST_CAPTURE_DR:
            next_state = TMS ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_SHIFT_DR:
            next_state = TMS ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_EXIT1_DR:
            next_state = TMS ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_PAUSE_DR:
            next_state = TMS ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_EXIT2_DR:
            next_state = TMS ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_UPDATE_DR:
            next_state = TMS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR:
            next_state = TMS ? bst_pkg::ST_RESET : bst_pkg::ST_CAPTURE_IR;
         bst_pkg::ST_CAPTURE_IR:
            next_state = TMS ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_SHIFT_IR:
            next_state = TMS ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_EXIT1_IR:
            next_state = TMS ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_PAUSE_IR:
            next_state = TMS ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_EXIT2_IR:
            next_state = TMS ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_UPDATE_IR:
            next_state = TMS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         default:
            next_state = bst_pkg::ST_RESET;
      endcase
      // A held power-up reset keeps the controller in Test-Logic-Reset.
      if (rst_tck)
      begin
         next_state = bst_pkg::ST_RESET;
      end
   end

   // Shift paths: instruction stages, pass stage and pin cell chain.
   always_comb
   begin
      next_ir_shift = ir_shift;
      next_pass_stage = pass_stage;
      next_chain = chain;
      if (state == bst_pkg::ST_CAPTURE_IR)
      begin
         next_ir_shift = bst_pkg::IR_CAPTURE_PATTERN;
      end
      else if (state == bst_pkg::ST_SHIFT_IR)
      begin
         next_ir_shift = {TDI, ir_shift[bst_pkg::IR_WIDTH-1:1]};
      end
      // Capture loads only the pin chain; the pass stage keeps its bit.
      if (dr_ctl.capture && sel_chain)
      begin
         next_chain = sense_tck;
      end
      else if (dr_ctl.shift && sel_chain)
      begin
         next_chain = {TDI, chain[bst_pkg::CELL_COUNT-1:1]};
      end
      else if (dr_ctl.shift)
      begin
         next_pass_stage = TDI;
      end
      // Every other state, Pause and Update included, leaves the stages as they are.
   end

   // Rising edge registers; test reset acts at once, even with the clock stopped.
   always_ff @(posedge TCK or negedge TRST_N)
   begin
      if (!TRST_N)
      begin
         state <= bst_pkg::ST_RESET;
         ir_shift <= bst_pkg::IR_CAPTURE_PATTERN;
         pass_stage <= 1'b0;
         chain <= '0;
      end
      else
      begin
         state <= next_state;
         ir_shift <= next_ir_shift;
         pass_stage <= next_pass_stage;
         chain <= next_chain;
      end
   end

   // Falling edge updates: current instruction, output latches and serial output.
   always_comb
   begin
      next_ir_cur = ir_cur;
      next_cell_latch = cell_latch;
      next_upd_toggle = upd_toggle;
      next_tdo_q.drive = 1'b0;
      next_tdo_q.enable = 1'b0;
      if (state == bst_pkg::ST_RESET)
      begin
         next_ir_cur = bst_pkg::INSTR_BYPASS;
      end
      else if (state == bst_pkg::ST_UPDATE_IR)
      begin
         next_ir_cur = ir_shift;
      end
      // Latches move only here, so the pins stay still while the chain ripples.
      if (dr_ctl.update && sel_chain)
      begin
         next_cell_latch = chain;
         next_upd_toggle = !upd_toggle;
      end
      // One shared serial output; the state and, in Shift-DR, the current instruction pick the path behind it.
      if (state == bst_pkg::ST_SHIFT_IR)
      begin
         next_tdo_q.drive = ir_shift[0];
         next_tdo_q.enable = 1'b1;
      end
      else if (dr_ctl.shift)
      begin
         next_tdo_q.drive = sel_chain ? chain[0] : pass_stage;
         next_tdo_q.enable = 1'b1;
      end
   end

   // Falling edge registers share the asynchronous test reset.
   always_ff @(negedge TCK or negedge TRST_N)
   begin
      if (!TRST_N)
      begin
         ir_cur <= bst_pkg::INSTR_BYPASS;
         cell_latch <= '0;
         upd_toggle <= 1'b0;
         tdo_q <= '0;
      end
      else
      begin
         ir_cur <= next_ir_cur;
         cell_latch <= next_cell_latch;
         upd_toggle <= next_upd_toggle;
         tdo_q <= next_tdo_q;
      end
   end

   // The serial output pin comes straight from its falling edge flops.
   assign TDO = tdo_q.drive;
   assign TDO_OE = tdo_q.enable;

   // System side copies the latch word once its update toggle has settled.
   always_comb
   begin
      next_upd_seen = upd_toggle_clk;
      next_pin_drive = pin_drive;
      next_test_mode = extest_clk;
      if (upd_toggle_clk != upd_seen)
      begin
         next_pin_drive = cell_latch;
      end
   end

   // System clock registers with synchronous reset.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         upd_seen <= next_upd_seen; // Tracks the toggle so reset leaves no false edge.
         pin_drive <= '0;
         test_mode <= 1'b0;
      end
      else
      begin
         upd_seen <= next_upd_seen;
         pin_drive <= next_pin_drive;
         test_mode <= next_test_mode;
      end
   end

   assign PIN_DRIVE = pin_drive;
   assign PIN_TEST_MODE = test_mode;

   // Mode select held high for the full reset count.
   sequence tms_high_run_s;
      TMS [*5];
   endsequence

   // Entry into Shift-IR from Capture-IR.
   sequence ir_capture_then_shift_s;
      (state == bst_pkg::ST_CAPTURE_IR) ##1 (state == bst_pkg::ST_SHIFT_IR);
   endsequence
   property tms_reset_p;
      @(posedge TCK) disable iff (tck_rst)
      tms_high_run_s |=> (state == bst_pkg::ST_RESET);
   endproperty
   property ir_capture_p;
      @(posedge TCK) disable iff (tck_rst)
      ir_capture_then_shift_s |-> (ir_shift == bst_pkg::IR_CAPTURE_PATTERN);
   endproperty
   property ir_shift_p;
      @(posedge TCK) disable iff (tck_rst)
      (state == bst_pkg::ST_SHIFT_IR) |=>
         (ir_shift == {$past(TDI), $past(ir_shift[bst_pkg::IR_WIDTH-1:1])});
   endproperty
   property chain_shift_p;
      @(posedge TCK) disable iff (tck_rst)
      (dr_ctl.shift && sel_chain) |=>
         (chain == {$past(TDI), $past(chain[bst_pkg::CELL_COUNT-1:1])});
   endproperty
   property pass_hold_p;
      @(posedge TCK) disable iff (tck_rst)
      (!dr_ctl.shift) |=> $stable(pass_stage);
   endproperty
   property dr_hold_p;
      @(posedge TCK) disable iff (tck_rst)
      (!dr_ctl.shift && !dr_ctl.capture) |=> $stable(chain);
   endproperty
   property latch_still_p;
      @(posedge TCK) disable iff (tck_rst)
      (state != bst_pkg::ST_UPDATE_DR) |-> $stable(cell_latch);
   endproperty
   property ir_take_p;
      @(posedge TCK) disable iff (tck_rst)
      (state == bst_pkg::ST_UPDATE_IR) |-> (ir_cur == ir_shift);
   endproperty
   property ir_keep_p;
      @(posedge TCK) disable iff (tck_rst)
      (state != bst_pkg::ST_UPDATE_IR && state != bst_pkg::ST_RESET) |-> $stable(ir_cur);
   endproperty
   property reset_pass_p;
      @(posedge TCK) disable iff (tck_rst)
      $past(state == bst_pkg::ST_RESET) && (state == bst_pkg::ST_RESET) |->
         (ir_cur == bst_pkg::INSTR_BYPASS);
   endproperty
   property tdo_quiet_p;
      @(posedge TCK) disable iff (tck_rst)
      (state != bst_pkg::ST_SHIFT_DR && state != bst_pkg::ST_SHIFT_IR) |-> !TDO_OE;
   endproperty
   property drive_follow_p;
      @(posedge CLOCK) disable iff (RST)
      (upd_toggle_clk != upd_seen) |=> (PIN_DRIVE == $past(cell_latch));
   endproperty
   tms_reset_a: assert property (tms_reset_p) else $error("five high TMS edges missed reset");
   ir_capture_a: assert property (ir_capture_p) else $error("capture pattern not loaded");
   ir_shift_a: assert property (ir_shift_p) else $error("instruction stages did not shift");
   chain_shift_a: assert property (chain_shift_p) else $error("pin chain did not shift");
   pass_hold_a: assert property (pass_hold_p) else $error("pass stage moved outside shift");
   dr_hold_a: assert property (dr_hold_p) else $error("pin chain moved while holding");
   latch_still_a: assert property (latch_still_p) else $error("latch moved outside update");
   ir_take_a: assert property (ir_take_p) else $error("update did not take instruction");
   ir_keep_a: assert property (ir_keep_p) else $error("current instruction changed");
   reset_pass_a: assert property (reset_pass_p) else $error("reset did not select pass");
   tdo_quiet_a: assert property (tdo_quiet_p) else $error("serial output driven off shift");
   drive_follow_a: assert property (drive_follow_p) else $error("pin drive not copied");

endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the boundary-scan test port driven by the scan controller model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic CLOCK, RST, TCK, TMS, TDI, TRST_N, TDO, TDO_OE, PIN_TEST_MODE;
   logic [bst_pkg::CELL_COUNT-1:0] PIN_SENSE;
   logic [bst_pkg::CELL_COUNT-1:0] PIN_DRIVE;
   logic [15:0] exp_q[$];
   logic [15:0] seen_q[$];
   logic [15:0] dout;
   logic [15:0] pin_exp;
   logic [31:0] rnd;
   logic [3:0] codes[3];
   logic ok;
   int err_total, tests_run, seed;

   bst_tap dut (.CLOCK(CLOCK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N),
      .TDO(TDO), .TDO_OE(TDO_OE), .PIN_SENSE(PIN_SENSE), .PIN_DRIVE(PIN_DRIVE),
      .PIN_TEST_MODE(PIN_TEST_MODE));
   bst_scan_host host (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO),
      .TDO_OE(TDO_OE));

   // System clock at 4 ns.
   initial
   begin
      CLOCK = 1'b0;
      forever #2 CLOCK = ~CLOCK;
   end

   // Compares one result with its note and reports a mismatch.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Notes an expectation and hands the observed result to the monitor.
   task automatic expect_val(input logic [15:0] seen, input logic [15:0] exp);
      exp_q.push_back(exp);
      seen_q.push_back(seen);
   endtask

   // Monitor takes the oldest note whenever a result appears.
   initial
   begin
      forever
      begin
         wait (seen_q.size() > 0);
         check(seen_q.pop_front(), exp_q.pop_front());
      end
   end

   task automatic clk_wait(input int n);
      repeat (n) @(posedge CLOCK);
   endtask

   task automatic done_test(input string name);
      $display("Test done: %s", name);
   endtask

   // Loads an instruction; the bits shifted out must be the fixed capture pattern.
   task automatic ir_load(input logic [3:0] code, input int pause_at);
      host.scan(1'b1, 4, {12'h000, code}, pause_at, dout, ok);
      expect_val(dout, {12'h000, bst_pkg::IR_CAPTURE_PATTERN});
      expect_val({15'h0000, ok}, 16'h0001);
   endtask

   // Eight bits go through the pass path; the first seven come back one period late.
   task automatic bypass_check;
      rnd = $random(seed);
      host.scan(1'b0, 8, rnd[15:0], 0, dout, ok);
      expect_val((dout >> 1) & 16'h007f, rnd[15:0] & 16'h007f);
      expect_val({15'h0000, ok}, 16'h0001);
   endtask

   // Full chain scan with a pause in the middle, then the parallel outputs are checked.
   task automatic dr16;
      logic [15:0] d;
      @(posedge CLOCK);
      rnd = $random(seed);
      PIN_SENSE <= rnd[15:0];
      host.run(1'b0, 3);
      rnd = $random(seed);
      d = rnd[15:0];
      pin_exp = d;
      host.scan(1'b0, 16, d, 8, dout, ok);
      expect_val(dout, PIN_SENSE);
      expect_val({15'h0000, ok}, 16'h0001);
      clk_wait(10);
      expect_val(PIN_DRIVE, d);
   endtask

   // Main sequence.
   initial
   begin
      seed = 20795;
      err_total = 0;
      tests_run = 0;
      RST = 1'b1;
      PIN_SENSE = 16'h0000;
      codes = '{4'h5, 4'ha, bst_pkg::INSTR_BYPASS};
      clk_wait(8);
      // Test clock runs under system reset so the reset synchroniser holds a known level.
      host.run(1'b1, 3);
      @(posedge CLOCK);
      RST <= 1'b0;
      host.trst_pulse();
      host.run(1'b1, 3);
      host.run(1'b0, 1);
      bypass_check();
      expect_val({15'h0000, TDO_OE}, 16'h0000);
      done_test("pass path after reset");
      foreach (codes[i])
      begin
         ir_load(codes[i], i);
         bypass_check();
      end
      done_test("other codes select the pass stage");
      ir_load(bst_pkg::INSTR_SAMPLE, 0);
      expect_val(PIN_DRIVE, 16'h0000);
      dr16();
      expect_val({15'h0000, PIN_TEST_MODE}, 16'h0000);
      done_test("sample and preload");
      ir_load(bst_pkg::INSTR_EXTEST, 2);
      expect_val(PIN_DRIVE, pin_exp);
      dr16();
      expect_val({15'h0000, PIN_TEST_MODE}, 16'h0001);
      done_test("extest");
      @(posedge CLOCK);
      RST <= 1'b1;
      host.run(1'b0, 4);
      @(posedge CLOCK);
      RST <= 1'b0;
      host.run(1'b1, 3);
      host.run(1'b0, 1);
      clk_wait(10);
      expect_val(PIN_DRIVE, 16'h0000);
      expect_val({15'h0000, PIN_TEST_MODE}, 16'h0000);
      done_test("system reset");
      ir_load(bst_pkg::INSTR_EXTEST, 0);
      clk_wait(10);
      expect_val({15'h0000, PIN_TEST_MODE}, 16'h0001);
      host.run(1'b1, 5);
      clk_wait(10);
      expect_val({15'h0000, PIN_TEST_MODE}, 16'h0000);
      host.run(1'b0, 1);
      bypass_check();
      done_test("mode select reset");
      clk_wait(4);
      finish_test();
   end

   // Watchdog sized well beyond the expected run of about 3.5 us.
   initial
   begin
      #200000;
      err_total++;
      $display("Watchdog expired");
      finish_test();
   end

   task automatic finish_test;
      $display("Counts: %0d compared, %0d mismatched", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
endmodule
`default_nettype wire
